// ### pkg/acq_pkg.sv
package acq_pkg;
    // Trigger source encodings
    localparam logic [1:0] TRIG_SOFT      = 2'h0;
    localparam logic [1:0] TRIG_EXT       = 2'h1;
    localparam logic [1:0] TRIG_THRESH    = 2'h2;
    // Retrigger source encodings
    localparam logic       RETRIG_INT     = 1'h0;
    localparam logic       RETRIG_EXT     = 1'h1;
    // Wrap modes
    localparam logic       WRAP_NONE      = 1'h0;
    localparam logic       WRAP_MULTIPLE  = 1'h1;
    // Threshold code width and sample widths
    localparam int         THRESH_W       = 8;
    localparam int         RES_W          = 16;
    // Raw converter code width used for clamping (two bits wider than the sample width)
    localparam int         RAW_W          = 18;
    // Fifo depth default
    localparam int         FIFO_DEPTH     = 32;
    // Acquisition states, Gray coded along idle-run-drain-wait
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_RUN   = 3'h1,
        ST_DRAIN = 3'h3,
        ST_WAIT  = 3'h2,
        ST_ERROR = 3'h6
    } acq_state_t;
endpackage

// ### sim/acq_monitor.sv
`timescale 1ns/1ns
module acq_monitor #(
    parameter int RES = 16
) (
    // Clock and reset
    input  wire logic           CLK_SYS_I,
    input  wire logic           RESET_I,
    // Configuration and commands
    input  wire logic [1:0]     TRIG_SRC_I,
    input  wire logic           EXT_FALLING_I,
    input  wire logic           TRIG_SCAN_EN_I,
    input  wire logic           ARM_I,
    input  wire logic           SW_START_I,
    input  wire logic           ABORT_I,
    input  wire logic           CLR_OVERSAMPLE_I,
    input  wire logic           CLR_OVERFLOW_I,
    input  wire logic           EXT_TRIG_I,
    // Converter and stream
    input  wire logic           SAMPLE_CLK_I,
    input  wire logic           CONV_START_O,
    input  wire logic           CONV_BUSY_I,
    input  wire logic           DATA_VALID_O,
    input  wire logic           DATA_READY_I,
    input  wire logic [RES-1:0] DATA_O,
    // Status
    input  wire logic           BUF_DONE_O,
    input  wire logic           ACTIVE_O,
    input  wire logic           WAITING_O,
    input  wire logic           OVERSAMPLE_O,
    input  wire logic           OVERFLOW_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);

    // Conversions only on a clean sample clock
    conv_gate_a: assert property (CONV_START_O |-> SAMPLE_CLK_I && !CONV_BUSY_I)
        else $error("conversion started without a clean sample clock");
    oversample_set_a: assert property (SAMPLE_CLK_I && CONV_BUSY_I && ACTIVE_O && !ABORT_I |=> OVERSAMPLE_O)
        else $error("over-sample not flagged");
    oversample_hold_a: assert property (OVERSAMPLE_O && !CLR_OVERSAMPLE_I |=> OVERSAMPLE_O)
        else $error("over-sample flag dropped without clear");
    overflow_hold_a: assert property (OVERFLOW_O && !CLR_OVERFLOW_I |=> OVERFLOW_O)
        else $error("overflow flag dropped without clear");
    error_halt_a: assert property ((OVERSAMPLE_O || OVERFLOW_O) |-> !CONV_START_O && !DATA_VALID_O)
        else $error("acquisition or transfer continued in error");
    buf_pulse_a: assert property (BUF_DONE_O |=> !BUF_DONE_O)
        else $error("buffer done longer than one cycle");
    abort_idle_a: assert property (ABORT_I |=> !ACTIVE_O && !WAITING_O && !DATA_VALID_O)
        else $error("abort did not halt at once");
    idle_ignore_a: assert property (!ACTIVE_O && !WAITING_O && !ARM_I |=> !ACTIVE_O)
        else $error("started without being armed");
    soft_start_a: assert property (WAITING_O && !TRIG_SCAN_EN_I && TRIG_SRC_I == acq_pkg::TRIG_SOFT
                                   && SW_START_I && !ABORT_I |=> ACTIVE_O)
        else $error("software start not taken");
    ext_edge_a: assert property (WAITING_O && !TRIG_SCAN_EN_I && TRIG_SRC_I == acq_pkg::TRIG_EXT
                                 && (EXT_FALLING_I ? $fell(EXT_TRIG_I) : $rose(EXT_TRIG_I))
                                 |-> ##[1:5] ACTIVE_O)
        else $error("external edge not taken");
    // Stream words stand until taken, unless an abort or an error cuts the transfer
    stream_hold_a: assert property (DATA_VALID_O && !DATA_READY_I && !ABORT_I ##1 !OVERSAMPLE_O && !OVERFLOW_O
                                    |-> DATA_VALID_O && $stable(DATA_O))
        else $error("stream word changed before it was taken");
endmodule

bind acq_trigger_ctrl acq_monitor #(.RES(RES)) acq_monitor_inst (
    .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .TRIG_SRC_I(TRIG_SRC_I), .EXT_FALLING_I(EXT_FALLING_I),
    .TRIG_SCAN_EN_I(TRIG_SCAN_EN_I), .ARM_I(ARM_I), .SW_START_I(SW_START_I), .ABORT_I(ABORT_I),
    .CLR_OVERSAMPLE_I(CLR_OVERSAMPLE_I), .CLR_OVERFLOW_I(CLR_OVERFLOW_I), .EXT_TRIG_I(EXT_TRIG_I),
    .SAMPLE_CLK_I(SAMPLE_CLK_I), .CONV_START_O(CONV_START_O), .CONV_BUSY_I(CONV_BUSY_I),
    .DATA_VALID_O(DATA_VALID_O), .DATA_READY_I(DATA_READY_I), .DATA_O(DATA_O), .BUF_DONE_O(BUF_DONE_O),
    .ACTIVE_O(ACTIVE_O), .WAITING_O(WAITING_O), .OVERSAMPLE_O(OVERSAMPLE_O), .OVERFLOW_O(OVERFLOW_O));

// ### sim/host_model.sv
`timescale 1ns/1ns
module host_model (
    // Clock and control
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic stall_i,
    // Stream from the device
    input  wire logic valid_i,
    output logic      ready_o
);
    int seed;

    initial begin
        seed = 95757;
        ready_o = 1'b0;
    end
    // Ragged draining; stall models a host too slow to keep up
    always @(negedge clk_i) begin
        if (rst_i || stall_i) ready_o <= 1'b0;
        else ready_o <= ($random(seed) % 3) != 0;
    end
endmodule

// ### sim/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk, rst, ext_trig, samp_clk, busy, done, stall, falling, scan_en, retrig_src, wrap;
    logic        [1:0]  src;
    logic        [7:0]  thr, scans;
    logic        [9:0]  cgl;
    logic        [23:0] nsamp;
    logic        [15:0] bsize, dout;
    logic        [3:0]  bcount, bidx;
    logic        [6:0]  cmd;
    logic signed [17:0] raw;
    logic conv_start, dvalid, dready, bdone, active, waiting, ovs, ovf;
    int err_count, n_compared, bd_count, seed, started;
    logic        [15:0] exp_q[$];
    logic signed [17:0] corners[5] = '{-18'sd40000, -18'sd32768, 18'sd0, 18'sd32767, 18'sd40000};

    acq_trigger_ctrl acq_trigger_ctrl_inst (
        .CLK_SYS_I(clk), .RESET_I(rst), .TRIG_SRC_I(src), .EXT_FALLING_I(falling), .TRIG_SCAN_EN_I(scan_en),
        .RETRIG_SRC_I(retrig_src), .WRAP_MODE_I(wrap), .THRESH_CODE_I(thr), .CGL_LEN_I(cgl),
        .SCANS_PER_TRIG_I(scans), .SAMPLE_COUNT_I(nsamp), .BUF_SIZE_I(bsize), .BUF_COUNT_I(bcount),
        .ARM_I(cmd[0]), .SW_START_I(cmd[1]), .STOP_I(cmd[2]), .ABORT_I(cmd[3]), .CLR_OVERSAMPLE_I(cmd[4]),
        .CLR_OVERFLOW_I(cmd[5]), .INT_RETRIG_I(cmd[6]), .EXT_TRIG_I(ext_trig), .SAMPLE_CLK_I(samp_clk),
        .CONV_START_O(conv_start), .CONV_BUSY_I(busy), .CONV_DONE_I(done), .CONV_RAW_I(raw),
        .DATA_VALID_O(dvalid), .DATA_READY_I(dready), .DATA_O(dout), .BUF_DONE_O(bdone),
        .BUF_INDEX_O(bidx), .ACTIVE_O(active), .WAITING_O(waiting), .OVERSAMPLE_O(ovs), .OVERFLOW_O(ovf));
    host_model host_model_inst (.clk_i(clk), .rst_i(rst), .stall_i(stall), .valid_i(dvalid), .ready_o(dready));

    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Offset binary with saturation
    function automatic logic [15:0] code_of(input logic signed [17:0] r);
        if (r > 18'sd32767) return 16'hffff;
        if (r < -18'sd32768) return 16'h0000;
        return 16'(r + 18'sd32768);
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic pulse(input int k);
        @(negedge clk);
        cmd[k] = 1'b1;
        @(negedge clk);
        cmd[k] = 1'b0;
    endtask
    // Converter answer; raw code does not linger after the strobe
    task automatic cdone(input logic signed [17:0] r);
        done = 1'b1;
        raw = r;
        @(negedge clk);
        done = 1'b0;
        raw = ~r;
    endtask
    task automatic samp(input logic signed [17:0] r, input logic pre_busy);
        @(negedge clk);
        samp_clk = 1'b1;
        busy = pre_busy;
        #1;
        started = int'(conv_start === 1'b1);
        @(negedge clk);
        samp_clk = 1'b0;
        busy = 1'b0;
        if (started != 0) begin
            busy = 1'b1;
            repeat (2) @(negedge clk);
            busy = 1'b0;
            exp_q.push_back(code_of(r));
            cdone(r);
        end
    endtask
    task automatic drain;
        for (int i = 0; i < 500 && exp_q.size() != 0; i++) @(negedge clk);
        check("drained", exp_q.size(), 0);
    endtask
    task automatic go(input logic [1:0] s);
        src = s;
        pulse(0);
        check("waiting", waiting, 1);
        if (s == acq_pkg::TRIG_SOFT) pulse(1);
    endtask
    // Scoreboard and buffer-done counter
    always @(posedge clk) begin
        if (!rst && dvalid === 1'b1 && dready === 1'b1) begin
            if (exp_q.size() == 0) check("extra word", 1, 0);
            else check("data", dout, exp_q.pop_front());
        end
        if (!rst && bdone === 1'b1) bd_count++;
    end
    // Watchdog, generous against the few hundred cycles expected
    initial begin
        #(40 * 60000);
        err_count++;
        close_out();
    end

    initial begin
        seed = 95757;
        rst = 1'b1;
        {ext_trig, samp_clk, busy, done, stall, falling, scan_en, retrig_src, wrap} = '0;
        src = acq_pkg::TRIG_SOFT;
        {thr, scans, cgl, nsamp, bsize, bcount, cmd, raw} = {8'h00, 8'h01, 10'h002, 24'h000008, 16'h0004,
                                                              4'h2, 7'h00, 18'h00000};
        err_count = 0;
        n_compared = 0;
        bd_count = 0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        // Soft start, run to sample count across two buffers
        go(acq_pkg::TRIG_SOFT);
        check("active", active, 1);
        for (int i = 0; i < 8; i++) samp(i < 5 ? corners[i] : 18'($random(seed) % 40000), 1'b0);
        drain();
        check("buffers done", bd_count, 2);
        check("ended", active, 0);
        samp(18'sd5, 1'b0);
        check("no sample after end", started, 0);
        $display("test soft_run done");
        // Wrap multiple past the only buffer, then orderly stop mid-pass
        {wrap, bcount, bd_count} = {1'b1, 4'h1, 32'd0};
        go(acq_pkg::TRIG_SOFT);
        for (int i = 0; i < 9; i++) samp(18'($random(seed) % 32768), 1'b0);
        check("still running", active, 1);
        pulse(2);
        samp(18'sd77, 1'b0);
        check("pass completes", started, 1);
        samp(18'sd78, 1'b0);
        check("stopped", started, 0);
        drain();
        check("wrapped buffers", bd_count, 2);
        check("same buffer", bidx, 0);
        $display("test wrap_stop done");
        // Falling external edge, then abort and ignored triggers
        @(negedge clk);
        {falling, ext_trig} = 2'b11;
        go(acq_pkg::TRIG_EXT);
        ext_trig = 1'b0;
        repeat (6) @(negedge clk);
        check("ext start", active, 1);
        pulse(3);
        check("aborted", active | waiting, 0);
        ext_trig = 1'b1;
        repeat (4) @(negedge clk);
        ext_trig = 1'b0;
        pulse(1);
        repeat (6) @(negedge clk);
        check("triggers ignored", active, 0);
        $display("test ext_abort done");
        // Triggered scan with internal retrigger
        {scan_en, retrig_src} = 2'b10;
        go(acq_pkg::TRIG_SOFT);
        samp(18'sd1, 1'b0);
        samp(18'sd2, 1'b0);
        repeat (2) @(negedge clk);
        check("wait retrigger", waiting, 1);
        samp(18'sd3, 1'b0);
        check("clock ignored in wait", started, 0);
        pulse(6);
        check("retriggered", active, 1);
        drain();
        pulse(3);
        $display("test retrigger done");
        // Threshold: code 40h is raw 8192, strictly above needed (host code in 0..255)
        {scan_en, stall, thr} = {2'b01, 8'h40};
        go(acq_pkg::TRIG_THRESH);
        cdone(18'sd8192);
        repeat (2) @(negedge clk);
        check("at threshold", active, 0);
        cdone(18'sd8193);
        repeat (2) @(negedge clk);
        check("above threshold", active, 1);
        pulse(3);
        exp_q.delete();
        stall = 1'b0;
        $display("test threshold done");
        // Over-sample halts and sticks until cleared
        go(acq_pkg::TRIG_SOFT);
        samp(18'sd9, 1'b1);
        repeat (5) @(negedge clk);
        check("oversample", ovs, 1);
        check("halted", active, 0);
        pulse(4);
        check("oversample cleared", ovs, 0);
        $display("test oversample done");
        // Stalled host: fifo fills and overflows, flag re-raised while full
        stall = 1'b1;
        go(acq_pkg::TRIG_SOFT);
        for (int i = 0; i < 36; i++) samp(18'($random(seed) % 32768), 1'b0);
        check("overflow", ovf, 1);
        check("no transfer", dvalid | active, 0);
        pulse(5);
        repeat (2) @(negedge clk);
        check("overflow again", ovf, 1);
        pulse(3);
        exp_q.delete();
        pulse(5);
        check("overflow cleared", ovf, 0);
        stall = 1'b0;
        $display("test overflow done");
        close_out();
    end
endmodule

// ### src/acq_fifo.sv
`timescale 1ns/1ns
module acq_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             flush_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    // Handshake decode; full and empty straight from the count
    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_r];

    // Pointer and count next values
    always_comb begin
        wr_nxt  = wr_r;
        rd_nxt  = rd_r;
        cnt_nxt = cnt_r;
        if (flush_i) begin
            wr_nxt  = '0;
            rd_nxt  = '0;
            cnt_nxt = '0;
        end else begin
            if (push) begin
                wr_nxt = (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + AW'(1);
            end
            if (pop) begin
                rd_nxt = (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + AW'(1);
            end
            cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Pointer registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset, so it stays a plain memory
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_r] <= in_data_i;
        end
    end
endmodule

// ### src/acq_trigger_ctrl.sv
`timescale 1ns/1ns
// Summary of operation
// - Start on initial trigger; end on sample count (wrap none) or host stop.
// - Orderly stop finishes the current channel-gain pass before halting.
// - Triggered scan keeps going, each later group started by the retrigger source.
// - Software source: the host start write is the trigger event.
// - External source: trigger on chosen edge of the external trigger input.
// - Threshold source: trigger when first-entry channel rises above threshold.
// - Threshold is an 8-bit code, 0 is zero volts, 255 is ten volts.
// - Samples leave as offset binary, all zeros negative, all ones positive.
// - Out-of-range converter results saturate to all ones or all zeros.
// - Signal buffer done each time one host buffer is full.
// - Wrap none fills buffers in turn and stops when none remain empty.
// - Wrap multiple fills buffers in turn, then rewrites the last from its start, runs until stopped.
// - Flag over-sample when a clock pulse comes while converting; host clears.
// - Flag FIFO overflow when not drained; reasserts while FIFO stays full.
// - Either error stops acquisition and transfer to host.
// - Abrupt stop halts at once, discards data, ignores later triggers.
// - External retrigger edges during acquisition are ignored.
module acq_trigger_ctrl #(
    parameter int RES        = 16,
    parameter int CGL_W      = 10,
    parameter int SCAN_W     = 8,
    parameter int BUF_W      = 16,
    parameter int NBUF_W     = 4,
    parameter int CNT_W      = 24,
    parameter int FIFO_DEPTH = acq_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                      CLK_SYS_I,
    input  wire logic                      RESET_I,
    // Host configuration
    input  wire logic [1:0]                TRIG_SRC_I,
    input  wire logic                      EXT_FALLING_I,
    input  wire logic                      TRIG_SCAN_EN_I,
    input  wire logic                      RETRIG_SRC_I,
    input  wire logic                      WRAP_MODE_I,
    input  wire logic [acq_pkg::THRESH_W-1:0] THRESH_CODE_I,
    input  wire logic [CGL_W-1:0]          CGL_LEN_I,
    input  wire logic [SCAN_W-1:0]         SCANS_PER_TRIG_I,
    input  wire logic [CNT_W-1:0]          SAMPLE_COUNT_I,
    input  wire logic [BUF_W-1:0]          BUF_SIZE_I,
    input  wire logic [NBUF_W-1:0]         BUF_COUNT_I,
    // Host commands, one-cycle pulses
    input  wire logic                      ARM_I,
    input  wire logic                      SW_START_I,
    input  wire logic                      STOP_I,
    input  wire logic                      ABORT_I,
    input  wire logic                      CLR_OVERSAMPLE_I,
    input  wire logic                      CLR_OVERFLOW_I,
    // External trigger and internal retrigger tick
    input  wire logic                      EXT_TRIG_I,
    input  wire logic                      INT_RETRIG_I,
    // Converter side
    input  wire logic                      SAMPLE_CLK_I,
    output logic                           CONV_START_O,
    input  wire logic                      CONV_BUSY_I,
    input  wire logic                      CONV_DONE_I,
    input  wire logic signed [acq_pkg::RAW_W-1:0] CONV_RAW_I,
    // Host data stream
    output logic                           DATA_VALID_O,
    input  wire logic                      DATA_READY_I,
    output logic [RES-1:0]                 DATA_O,
    // Status
    output logic                           BUF_DONE_O,
    output logic [NBUF_W-1:0]              BUF_INDEX_O,
    output logic                           ACTIVE_O,
    output logic                           WAITING_O,
    output logic                           OVERSAMPLE_O,
    output logic                           OVERFLOW_O
);
    // Saturating offset binary encoding of a signed raw result
    function automatic logic [RES-1:0] encode(input logic signed [acq_pkg::RAW_W-1:0] raw);
        logic signed [acq_pkg::RAW_W-1:0] lo, hi;
        lo = -(acq_pkg::RAW_W'(1) <<< (RES-1));
        hi = (acq_pkg::RAW_W'(1) <<< (RES-1)) - acq_pkg::RAW_W'(1);
        if (raw > hi) begin
            encode = '1;
        end else if (raw < lo) begin
            encode = '0;
        end else begin
            encode = RES'(raw - lo);
        end
    endfunction

    acq_pkg::acq_state_t st_r, st_nxt;
    logic                 ext_s1_r, ext_s2_r, ext_s3_r;
    logic                 ext_s1_nxt, ext_s2_nxt, ext_s3_nxt;
    logic                 above_r, above_nxt;
    logic                 ovs_r, ovs_nxt, ovf_r, ovf_nxt;
    logic [CGL_W-1:0]     cgl_r, cgl_nxt;
    logic [SCAN_W-1:0]    scan_r, scan_nxt;
    logic [CNT_W-1:0]     tot_r, tot_nxt;
    logic [BUF_W-1:0]     bpos_r, bpos_nxt;
    logic [NBUF_W-1:0]    bidx_r, bidx_nxt;
    logic [RES-1:0]       smp_r, smp_nxt;
    logic                 smpv_r, smpv_nxt;
    logic                 done_r, done_nxt;
    // Conversion in flight; its result is kept after the state leaves run, except into error or on abort
    logic                 pend_r, pend_nxt, capture;
    logic signed [acq_pkg::RAW_W-1:0] thr_level;
    logic                 ext_edge, thr_cross, init_trig, retrig, running;
    logic                 fifo_ready, flush, sample_go, last_entry, last_scan;

    // Edge of the synchronised trigger; stage one feeds only stage two
    assign ext_edge = EXT_FALLING_I ? (ext_s3_r && !ext_s2_r)
                                    : (!ext_s3_r && ext_s2_r);
    // Threshold code scaled onto the positive half of the span; signed so negative inputs stay below
    assign thr_level = signed'(acq_pkg::RAW_W'({THRESH_CODE_I, {(RES-1-acq_pkg::THRESH_W){1'b0}}}));
    assign thr_cross = CONV_DONE_I && (cgl_r == '0) && !above_r && (CONV_RAW_I > thr_level);
    // Last result of a pass lands after the state has moved on
    assign capture   = CONV_DONE_I && pend_r && (st_r != acq_pkg::ST_ERROR);

    // Initial trigger mux
    always_comb begin
        case (TRIG_SRC_I)
            acq_pkg::TRIG_SOFT:   init_trig = SW_START_I;
            acq_pkg::TRIG_EXT:    init_trig = ext_edge;
            acq_pkg::TRIG_THRESH: init_trig = thr_cross;
            default:              init_trig = 1'b0;
        endcase
    end

    // Retrigger only counts while waiting, edges during runs fall away
    assign retrig = (RETRIG_SRC_I == acq_pkg::RETRIG_EXT) ? ext_edge : INT_RETRIG_I;

    assign running    = (st_r == acq_pkg::ST_RUN) || (st_r == acq_pkg::ST_DRAIN);
    assign sample_go  = running && SAMPLE_CLK_I && !CONV_BUSY_I;
    assign last_entry = (cgl_r == CGL_LEN_I - CGL_W'(1));
    assign last_scan  = (scan_r == SCANS_PER_TRIG_I - SCAN_W'(1));
    assign flush      = ABORT_I;

    // Next state, counters and flags
    always_comb begin
        st_nxt     = st_r;
        ext_s1_nxt = EXT_TRIG_I;
        ext_s2_nxt = ext_s1_r;
        ext_s3_nxt = ext_s2_r;
        above_nxt  = above_r;
        cgl_nxt    = cgl_r;
        scan_nxt   = scan_r;
        tot_nxt    = tot_r;
        bpos_nxt   = bpos_r;
        bidx_nxt   = bidx_r;
        smp_nxt    = smp_r;
        smpv_nxt   = smpv_r && !fifo_ready;
        done_nxt   = 1'b0;
        pend_nxt   = (pend_r && !CONV_DONE_I) || sample_go;
        // Set wins over clear for both flags
        ovs_nxt = (ovs_r && !CLR_OVERSAMPLE_I) ||
                  (running && SAMPLE_CLK_I && CONV_BUSY_I);
        ovf_nxt = (ovf_r && !CLR_OVERFLOW_I) ||
                  (smpv_r && !fifo_ready);
        if (CONV_DONE_I && cgl_r == '0) begin
            above_nxt = thr_cross || (CONV_RAW_I > thr_level);
        end
        // Converted samples go to the FIFO and advance buffer tracking
        if (capture) begin
            smp_nxt  = encode(CONV_RAW_I);
            smpv_nxt = 1'b1;
            tot_nxt  = tot_r + CNT_W'(1);
            if (bpos_r == BUF_SIZE_I - BUF_W'(1)) begin
                bpos_nxt = '0;
                done_nxt = 1'b1;
                if (bidx_r == BUF_COUNT_I - NBUF_W'(1)) begin
                    if (WRAP_MODE_I == acq_pkg::WRAP_NONE) begin
                        st_nxt = acq_pkg::ST_IDLE;
                    end
                end else begin
                    bidx_nxt = bidx_r + NBUF_W'(1);
                end
            end else begin
                bpos_nxt = bpos_r + BUF_W'(1);
            end
            if (WRAP_MODE_I == acq_pkg::WRAP_NONE && tot_r == SAMPLE_COUNT_I - CNT_W'(1)) begin
                st_nxt = acq_pkg::ST_IDLE;
            end
        end
        if (sample_go) begin
            cgl_nxt = last_entry ? '0 : cgl_r + CGL_W'(1);
            if (last_entry) begin
                scan_nxt = last_scan ? '0 : scan_r + SCAN_W'(1);
                if (st_r == acq_pkg::ST_DRAIN) begin
                    st_nxt = acq_pkg::ST_IDLE;
                end else if (TRIG_SCAN_EN_I && last_scan) begin
                    st_nxt = acq_pkg::ST_WAIT;
                end
            end
        end
        case (st_r)
            acq_pkg::ST_IDLE: begin
                if (ARM_I) begin
                    st_nxt   = acq_pkg::ST_WAIT;
                    cgl_nxt  = '0;
                    scan_nxt = '0;
                    tot_nxt  = '0;
                    bpos_nxt = '0;
                    bidx_nxt = '0;
                end
            end
            acq_pkg::ST_WAIT: begin
                // First trigger uses the initial source, later ones the retrigger
                if ((tot_r == '0) ? init_trig : retrig) begin
                    st_nxt = acq_pkg::ST_RUN;
                end
            end
            acq_pkg::ST_RUN: begin
                if (STOP_I && st_nxt == acq_pkg::ST_RUN) begin
                    st_nxt = acq_pkg::ST_DRAIN;
                end
            end
            acq_pkg::ST_DRAIN: ;
            acq_pkg::ST_ERROR: begin
                if (!ovs_nxt && !ovf_nxt) begin
                    st_nxt = acq_pkg::ST_IDLE;
                end
            end
            default: st_nxt = acq_pkg::ST_IDLE;
        endcase
        if (STOP_I && st_r == acq_pkg::ST_WAIT) begin
            st_nxt = acq_pkg::ST_IDLE;
        end
        if (ovs_nxt || ovf_nxt) begin
            st_nxt = acq_pkg::ST_ERROR;
        end
        if (ABORT_I) begin
            st_nxt   = acq_pkg::ST_IDLE;
            smpv_nxt = 1'b0;
            pend_nxt = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            st_r     <= acq_pkg::ST_IDLE;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            above_r  <= 1'b0;
            ovs_r    <= 1'b0;
            ovf_r    <= 1'b0;
            cgl_r    <= '0;
            scan_r   <= '0;
            tot_r    <= '0;
            bpos_r   <= '0;
            bidx_r   <= '0;
            smp_r    <= '0;
            smpv_r   <= 1'b0;
            done_r   <= 1'b0;
            pend_r   <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            ext_s1_r <= ext_s1_nxt;
            ext_s2_r <= ext_s2_nxt;
            ext_s3_r <= ext_s3_nxt;
            above_r  <= above_nxt;
            ovs_r    <= ovs_nxt;
            ovf_r    <= ovf_nxt;
            cgl_r    <= cgl_nxt;
            scan_r   <= scan_nxt;
            tot_r    <= tot_nxt;
            bpos_r   <= bpos_nxt;
            bidx_r   <= bidx_nxt;
            smp_r    <= smp_nxt;
            smpv_r   <= smpv_nxt;
            done_r   <= done_nxt;
            pend_r   <= pend_nxt;
        end
    end

    // Output FIFO; drain stalls in error so nothing more reaches the host
    logic out_valid, out_ready;
    assign out_ready    = DATA_READY_I && (st_r != acq_pkg::ST_ERROR);
    assign DATA_VALID_O = out_valid && (st_r != acq_pkg::ST_ERROR);

    acq_fifo #(
        .WIDTH (RES),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLK_SYS_I),
        .rst_i       (RESET_I),
        .flush_i     (flush),
        .in_valid_i  (smpv_r),
        .in_ready_o  (fifo_ready),
        .in_data_i   (smp_r),
        .out_valid_o (out_valid),
        .out_ready_i (out_ready),
        .out_data_o  (DATA_O)
    );

    // Status and converter strobes
    assign CONV_START_O = sample_go;
    assign BUF_DONE_O   = done_r;
    assign BUF_INDEX_O  = bidx_r;
    assign ACTIVE_O     = running;
    assign WAITING_O    = (st_r == acq_pkg::ST_WAIT);
    assign OVERSAMPLE_O = ovs_r;
    assign OVERFLOW_O   = ovf_r;
endmodule
